/* File: gms_pkg.sv */
`default_nettype none
package gms_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_PINS = 4;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_MODE_LO = 8'h0e;
  localparam logic [7:0] IDX_MODE_HI = 8'h0f;
  localparam logic [7:0] IDX_ROUTE0 = 8'h12;
  localparam logic [7:0] IDX_ROUTE1 = 8'h13;
  localparam logic [7:0] IDX_ROUTE2 = 8'h14;
  localparam logic [7:0] IDX_ROUTE3 = 8'h15;
  localparam logic [7:0] IDX_LEVEL = 8'h41;
  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  // mode field layout: low pin of a pair in bits 3:0, high pin in bits 7:4
  localparam int unsigned MODE_W = 4;
  localparam int unsigned MODE_LO_LSB = 0;
  localparam int unsigned MODE_HI_LSB = 4;
  // route field layout
  localparam int unsigned ROUTE_REG_LSB = 3;
  localparam int unsigned ROUTE_REG_W = 5;
  localparam int unsigned ROUTE_BIT_W = 3;
  // status space: 32 registers of 8 bits starting at 0x40
  localparam logic [7:0] STAT_BASE = 8'h40;
  localparam int unsigned STAT_BITS = 256;
  localparam logic [4:0] STAT_SEL_LEVEL = 5'h01;
  // mode codes
  localparam logic [3:0] MODE_IN = 4'h0;
  localparam logic [3:0] MODE_IN_INV = 4'h1;
  localparam logic [3:0] MODE_OUT_LO = 4'h2;
  localparam logic [3:0] MODE_OUT_HI = 4'h3;
  localparam logic [3:0] MODE_ST = 4'h4;
  localparam logic [3:0] MODE_ST_INV = 4'h5;
  localparam logic [3:0] MODE_ST_OD0 = 4'h6;
  localparam logic [3:0] MODE_ST_OD1 = 4'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: gms_pin_drv.sv */
`timescale 1ns/1ps
`default_nettype none
module gms_pin_drv (
  // configuration
  input wire logic [3:0] mode,
  input wire logic [7:0] route,
  // status space
  input wire logic [255:0] status_vec,
  input wire logic [255:0] status_impl,
  // pin level
  input wire logic level,
  // pin drive and core-side value
  output logic drive_out,
  output logic drive_oe,
  output logic in_value
);
  import gms_pkg::*;

  // followed bit; route is reg*8+bit, which is exactly the bit index in the status space
  logic st_bit; // chosen status bit
  logic st_ok; // chosen bit exists and may be followed

  // pick the status bit and decide whether it is a real one
  always_comb begin
    st_ok = status_impl[route] && (route[7:ROUTE_REG_LSB] != STAT_SEL_LEVEL);
    st_bit = status_vec[route];
  end

  // mode decode; unused codes fall to a plain input so nothing fights the board
  always_comb begin
    drive_out = 1'b0;
    drive_oe = 1'b0;
    in_value = level;
    case (mode)
      MODE_IN: begin
        in_value = level;
      end
      MODE_IN_INV: begin
        in_value = ~level;
      end
      MODE_OUT_LO: begin
        drive_oe = 1'b1;
      end
      MODE_OUT_HI: begin
        drive_oe = 1'b1;
        drive_out = 1'b1;
      end
      MODE_ST: begin
        drive_oe = 1'b1;
        drive_out = st_ok & st_bit;
      end
      MODE_ST_INV: begin
        drive_oe = 1'b1;
        drive_out = st_ok & ~st_bit;
      end
      MODE_ST_OD0: begin
        drive_oe = ~st_ok | ~st_bit;
      end
      MODE_ST_OD1: begin
        drive_oe = ~st_ok | st_bit;
      end
      default: begin
        drive_oe = 1'b0;
      end
    endcase
  end
endmodule // gms_pin_drv
`default_nettype wire

/* File: gms_gpio_top.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gms_gpio_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [gms_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [gms_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [gms_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [gms_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device status space, register 0x40+n in bits 8n+7:8n
  input wire logic [gms_pkg::STAT_BITS-1:0] status_vec,
  input wire logic [gms_pkg::STAT_BITS-1:0] status_impl,
  // pins
  input wire logic [gms_pkg::NUM_PINS-1:0] pin_in,
  output logic [gms_pkg::NUM_PINS-1:0] pin_out,
  output logic [gms_pkg::NUM_PINS-1:0] pin_oe,
  // pin value for the core, after the selected input inversion
  output logic [gms_pkg::NUM_PINS-1:0] pin_value
);
  import gms_pkg::*;

  // write channel state
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next; // held write address
  logic aw_have_reg, aw_have_next; // write address captured
  logic [7:0] w_data_reg, w_data_next; // held low data byte
  logic w_en_reg, w_en_next; // byte lane 0 strobe
  logic w_have_reg, w_have_next; // write data captured
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next; // write address slot free
  logic wready_reg, wready_next; // write data slot free
  // read channel state
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic arready_reg, arready_next; // no read answer standing
  // configuration registers
  logic [7:0] mode_lo_reg, mode_lo_next; // pin_mode_low_pair
  logic [7:0] mode_hi_reg, mode_hi_next; // pin_mode_high_pair
  logic [7:0] route_reg [NUM_PINS], route_next [NUM_PINS]; // pinN_status_route
  // pin side
  logic [7:0] level_reg, level_next; // pin_level_readback
  logic [NUM_PINS-1:0] out_reg, out_next;
  logic [NUM_PINS-1:0] oe_reg, oe_next;
  logic [NUM_PINS-1:0] val_reg, val_next;
  // per-pin decode results
  logic [NUM_PINS-1:0] drv_out, drv_oe, drv_val;
  logic [15:0] mode_all; // all four mode fields, pin n in bits 4n+3:4n
  // decode helpers
  logic [7:0] w_idx, r_idx; // register index from byte address
  logic w_aligned, r_aligned; // address has no stray bits
  logic do_write; // both halves of a write are present
  logic w_hit, r_hit; // address maps to a register
  logic [7:0] r_byte; // selected register value

  assign mode_all = {mode_hi_reg, mode_lo_reg};
  // register index from the byte address; the low two bits must be zero
  assign w_idx = aw_addr_reg[9:2];
  assign r_idx = s_axi_araddr[9:2];
  assign w_aligned = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg[ADDR_W-1:10] == '0);
  assign r_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[ADDR_W-1:10] == '0);
  // a write waits while its answer stands, so bresp is never overwritten
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  // one pin decoder per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    gms_pin_drv u_drv (
      .mode(mode_all[i*MODE_W +: MODE_W]),
      .route(route_reg[i]),
      .status_vec(status_vec),
      .status_impl(status_impl),
      .level(pin_in[i]),
      .drive_out(drv_out[i]),
      .drive_oe(drv_oe[i]),
      .in_value(drv_val[i])
    );
  end

  // write path: address and data are taken independently, then written together
  always_comb begin
    aw_addr_next = aw_addr_reg;
    aw_have_next = aw_have_reg;
    w_data_next = w_data_reg;
    w_en_next = w_en_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    mode_lo_next = mode_lo_reg;
    mode_hi_next = mode_hi_reg;
    w_hit = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      route_next[p] = route_reg[p];
    end
    // capture each half when offered
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_addr_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_data_next = s_axi_wdata[7:0];
      w_en_next = s_axi_wstrb[0];
      w_have_next = 1'b1;
    end
    // commit once both halves are in
    if (do_write) begin
      if (w_aligned) begin
        if (w_idx == IDX_MODE_LO) begin
          w_hit = 1'b1;
          if (w_en_reg) begin
            mode_lo_next = w_data_reg;
          end
        end else if (w_idx == IDX_MODE_HI) begin
          w_hit = 1'b1;
          if (w_en_reg) begin
            mode_hi_next = w_data_reg;
          end
        end else if (w_idx >= IDX_ROUTE0 && w_idx <= IDX_ROUTE3) begin
          w_hit = 1'b1;
          if (w_en_reg) begin
            route_next[w_idx[1:0] - IDX_ROUTE0[1:0]] = w_data_reg;
          end
        end
      end
      // readback and unmapped space refuse writes with an error
      bresp_next = w_hit ? RESP_OKAY : RESP_SLVERR;
      bvalid_next = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // ready mirrors the free slot, kept in its own flop so the port is registered
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
  end

  // write path registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_reg <= '0;
      aw_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_en_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      mode_lo_reg <= RST_MODE;
      mode_hi_reg <= RST_MODE;
      for (int p = 0; p < NUM_PINS; p++) begin
        route_reg[p] <= RST_ROUTE;
      end
    end else begin
      aw_addr_reg <= aw_addr_next;
      aw_have_reg <= aw_have_next;
      w_data_reg <= w_data_next;
      w_en_reg <= w_en_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      mode_lo_reg <= mode_lo_next;
      mode_hi_reg <= mode_hi_next;
      for (int p = 0; p < NUM_PINS; p++) begin
        route_reg[p] <= route_next[p];
      end
    end
  end

  // read decode; the readback sits in the low byte, upper bits read zero
  // unmapped or misaligned reads answer zero with an error
  always_comb begin
    r_byte = 8'h00;
    r_hit = 1'b0;
    if (r_aligned) begin
      if (r_idx == IDX_MODE_LO) begin
        r_byte = mode_lo_reg;
        r_hit = 1'b1;
      end else if (r_idx == IDX_MODE_HI) begin
        r_byte = mode_hi_reg;
        r_hit = 1'b1;
      end else if (r_idx >= IDX_ROUTE0 && r_idx <= IDX_ROUTE3) begin
        r_byte = route_reg[r_idx[1:0] - IDX_ROUTE0[1:0]];
        r_hit = 1'b1;
      end else if (r_idx == IDX_LEVEL) begin
        r_byte = level_reg;
        r_hit = 1'b1;
      end
    end
  end

  // read path: one outstanding read, answered the cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = {{(DATA_W-8){1'b0}}, r_byte};
      rresp_next = r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // the address slot stays shut while an answer stands
    arready_next = !rvalid_next;
  end

  // read path registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      arready_reg <= arready_next;
    end
  end

  // pin side: raw level sampled in every mode, drive registered so pins never glitch
  // a status change reaches the pin one edge later; that lag buys glitch-free pins
  always_comb begin
    level_next = {{(8-NUM_PINS){1'b0}}, pin_in};
    out_next = drv_out;
    oe_next = drv_oe;
    val_next = drv_val;
  end

  // pin side registers; reset leaves every pin as an input
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= RST_LEVEL;
      out_reg <= '0;
      oe_reg <= '0;
      val_reg <= '0;
    end else begin
      level_reg <= level_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      val_reg <= val_next;
    end
  end

  // outputs straight from flip-flops
  // ready flags have flops of their own rather than an inverter on the slot flags
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign pin_value = val_reg;
endmodule // gms_gpio_top
`default_nettype wire

/* File: gms_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board around the four pins: a pull-up lifts any line nobody drives
module gms_board_model (
  // device drive
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  // other board drivers
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  // resolved line level
  output logic [3:0] pin_in
);
  // device drive first, then a board driver, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // gms_board_model
`default_nettype wire

/* File: gms_gpio_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gms_gpio_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // address and data of a write taken on one edge
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves taken at edge t are written at t+1, and the answer is seen at t+2
  a_wr_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_wr_ok: assert property ((s_wr ##0 s_axi_awaddr == 12'h038)
    |-> ##2 s_axi_bresp == 2'h0)
    else $error("mode write refused");
  a_ro_refused: assert property ((s_wr ##0 s_axi_awaddr == 12'h104)
    |-> ##2 s_axi_bresp == 2'h2)
    else $error("readback write accepted");
  a_unmapped_err: assert property ((s_wr ##0 s_axi_awaddr == 12'h040)
    |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write accepted");
  a_rd_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read not answered");
  a_ar_refused: assert property (s_rd |=> !s_axi_arready)
    else $error("read taken while answering");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // a read of the readback returns the raw line level
  a_level_read: assert property ((s_rd ##0 (s_axi_araddr == 12'h104 && $stable(pin_in)))
    |=> s_axi_rdata[3:0] == $past(pin_in, 2))
    else $error("readback differs from pins");
  // nothing driven or answered at the first edge after reset
  a_reset_quiet: assert property ($rose(rst_n) |-> pin_oe == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("active after reset");
endmodule // gms_gpio_chk
bind gms_gpio_top gms_gpio_chk u_chk (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_in(pin_in), .pin_oe(pin_oe));
`default_nettype wire

/* File: tb_gms_gpio_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gms_gpio_top;
  import gms_pkg::*;
  logic clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [255:0] status_vec, status_impl;
  logic [3:0] pin_in, pin_out, pin_oe, pin_value, ext_en, ext_val;
  int error_cnt, checks;
  // mode, status bit, board level, then expected oe, out, value, line level
  typedef struct packed {logic [3:0] m; logic st, ev, oe, out, val, lvl;} gms_row_t;
  gms_row_t rows [14] = '{{4'h0, 6'b000000}, {4'h0, 6'b010011}, {4'h1, 6'b010001},
    {4'h1, 6'b000010}, {4'h2, 6'b101000}, {4'h3, 6'b001111}, {4'h4, 6'b001000},
    {4'h4, 6'b101111}, {4'h5, 6'b001111}, {4'h5, 6'b101000}, {4'h6, 6'b001000},
    {4'h6, 6'b100011}, {4'h7, 6'b000011}, {4'h7, 6'b101000}};
  logic [11:0] regs [6] = '{12'h038, 12'h03c, 12'h048, 12'h04c, 12'h050, 12'h054};
  gms_gpio_top uut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .status_vec(status_vec),
    .status_impl(status_impl), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_value(pin_value));
  gms_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  // 20 mhz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // valid is flop-driven, so reading it at the falling edge predicts the next rising edge
  task automatic wait_ans(input logic is_rd);
    logic h;
    h = 1'b0;
    while (!h) begin
      @(negedge clock);
      h = is_rd ? s_axi_rvalid : s_axi_bvalid;
      rd = s_axi_rdata;
      rs = is_rd ? s_axi_rresp : s_axi_bresp;
      @(posedge clock);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ha && hw)) begin
      @(negedge clock);
      ha = ha || s_axi_awready;
      hw = hw || s_axi_wready;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    wait_ans(1'b0);
  endtask
  task automatic rdr(input logic [11:0] a);
    logic h;
    h = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!h) begin
      @(negedge clock);
      h = s_axi_arready;
      @(posedge clock);
    end
    s_axi_arvalid <= 1'b0;
    wait_ans(1'b1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // let pin updates land, then look between edges
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    status_vec = '0;
    status_impl = '1;
    {ext_en, ext_val} = 8'h00;
    error_cnt = 0;
    checks = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    wr(12'h048, 32'h0);
    // pin 0 through every used mode; the board drives it only in input modes
    foreach (rows[i]) begin
      status_vec[0] <= rows[i].st;
      ext_en[0] <= rows[i].m < 4'h2;
      ext_val[0] <= rows[i].ev;
      wr(12'h038, {28'h0, rows[i].m});
      settle();
      chk(pin_oe[0], rows[i].oe, "pin drive enable");
      if (rows[i].oe) chk(pin_out[0], rows[i].out, "pin level driven");
      chk(pin_value[0], rows[i].val, "core value");
      @(posedge clock);
      rdr(12'h104);
      chk(rd, {28'h0, 3'b111, rows[i].lvl}, "line readback");
    end
    // pin 3 follows register 0x42 bit 5, pin 2 points at the readback and is held low
    status_vec[21] <= 1'b1;
    status_vec[8] <= 1'b0; // inverted, a followed readback bit would drive pin 2 high
    wr(12'h054, 32'h15);
    wr(12'h050, 32'h08);
    wr(12'h03c, 32'h45);
    settle();
    chk({pin_oe[3:2], pin_out[3:2]}, 4'b1110, "followed bits");
    @(posedge clock);
    status_impl[21] <= 1'b0;
    settle();
    chk({pin_oe[3], pin_out[3]}, 2'b10, "unimplemented bit");
    @(posedge clock);
    wr(12'h040, 32'h5);
    chk(rs, RESP_SLVERR, "unmapped write");
    wr(12'h104, 32'hf);
    chk(rs, RESP_SLVERR, "readback write");
    rdr(12'h054);
    chk(rd, 32'h15, "route read back");
    chk(rs, RESP_OKAY, "route read response");
    rdr(12'h040);
    chk(rs, RESP_SLVERR, "unmapped read");
    // an unused code on purpose: the pin must float
    wr(12'h038, 32'h90);
    settle();
    chk(pin_oe[1:0], 2'b00, "unused code");
    // second reset in mid-run returns every mode and route register to zero
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (regs[k]) begin
      rdr(regs[k]);
      chk(rd, 32'h0, "reset value");
    end
    finish_test();
  end
  // watchdog well beyond the roughly two hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule // tb_gms_gpio_top
`default_nettype wire
